// ===== rtl/rsse_defs.vh
// constants of the rotate, subtract and skip execution block
`ifndef RSSE_DEFS_VH
`define RSSE_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RSSE_OFF_CMD 8'h00
`define RSSE_OFF_WORK 8'h04
`define RSSE_OFF_STATUS 8'h08
`define RSSE_OFF_PC 8'h0c
`define RSSE_OFF_STACK 8'h10
`define RSSE_MEM_REGION 1'b1
`define RSSE_ADDR_USED_MSB 7
`define RSSE_MEM_FLAG_BIT 7
`define RSSE_MEM_IDX_MSB 6
`define RSSE_MEM_IDX_LSB 2

// ----------------------------------------
// command register fields
// ----------------------------------------
`define RSSE_CMD_OP_MSB 4
`define RSSE_CMD_OP_LSB 0
`define RSSE_CMD_ADDR_MSB 12
`define RSSE_CMD_ADDR_LSB 8
`define RSSE_CMD_BIT_MSB 18
`define RSSE_CMD_BIT_LSB 16
`define RSSE_CMD_IMM_MSB 31
`define RSSE_CMD_IMM_LSB 24

// ----------------------------------------
// status register bits
// ----------------------------------------
`define RSSE_ST_CARRY 0
`define RSSE_ST_HALF 1
`define RSSE_ST_ZERO 2
`define RSSE_ST_WRAP 3
`define RSSE_ST_MIE 4
`define RSSE_ST_SKIP 5
`define RSSE_ST_BUSY 6
`define RSSE_ST_WR_MSB 4

// ----------------------------------------
// operation codes
// ----------------------------------------
`define RSSE_OP_EXIT_LIT 5'h00
`define RSSE_OP_INT_RET 5'h01
`define RSSE_OP_ROTL 5'h02
`define RSSE_OP_ROTL_W 5'h03
`define RSSE_OP_ROTLC 5'h04
`define RSSE_OP_ROTLC_W 5'h05
`define RSSE_OP_ROTR 5'h06
`define RSSE_OP_ROTR_W 5'h07
`define RSSE_OP_SUBB 5'h08
`define RSSE_OP_SUBB_M 5'h09
`define RSSE_OP_DECSKIP 5'h0a
`define RSSE_OP_DECSKIP_W 5'h0b
`define RSSE_OP_INCSKIP 5'h0c
`define RSSE_OP_INCSKIP_W 5'h0d
`define RSSE_OP_SET_BYTE 5'h0e
`define RSSE_OP_SET_BIT 5'h0f
`define RSSE_OP_SKIP_BIT1 5'h10
`define RSSE_OP_SUB 5'h11
`define RSSE_OP_SUB_M 5'h12
`define RSSE_OP_SUB_IMM 5'h13
`define RSSE_OP_NIB 5'h14
`define RSSE_OP_NIB_W 5'h15
`define RSSE_OP_SKIP_BYTE0 5'h16
`define RSSE_OP_COPY_SKIP0 5'h17
`define RSSE_OP_SKIP_BIT0 5'h18
`define RSSE_OP_ROTRC 5'h19
`define RSSE_OP_ROTRC_W 5'h1a

// ----------------------------------------
// misc values
// ----------------------------------------
`define RSSE_ALL_ONES 8'hff
`define RSSE_BYTE_ZERO 8'h00
`define RSSE_RESP_OKAY 2'b00
`define RSSE_RESP_SLVERR 2'b10
`define RSSE_ST_IDLE 2'b00
`define RSSE_ST_EXEC 2'b01
`define RSSE_ST_DUMMY 2'b10

`endif

// ===== rtl/rsse_top.v
// execution unit for rotate, subtract, skip and return operations
//
// Summary of operation
// - exit with literal: pc from stack, literal to work register, flags kept
// - interrupt return: pc from stack, master interrupt enable set to one
// - rotate left moves bit 7 into bit 0, flags kept
// - rotate left through carry: bit 7 to carry, old carry to bit 0
// - rotate right moves bit 0 into bit 7, flags kept
// - rotate right through carry: bit 0 to carry, old carry to bit 7
// - work-register variants write only the work register, memory untouched
// - subtract with borrow: work minus memory minus inverted carry, into work
// - memory form of subtract with borrow writes memory, same flags
// - after subtraction carry is one unless result negative
// - plain subtract: work minus memory, to work or memory, four flags
// - immediate subtract: work minus literal into work, four flags
// - decrement memory, write back, skip when zero, flags kept
// - decrement into work register, skip when work becomes zero
// - increment memory, write back, skip when wrapped to zero
// - increment into work register, skip when work becomes zero
// - every skip-type operation takes two cycles with a dummy cycle
// - byte set writes all ones, bit set forces one bit, flags kept
// - skip when selected bit is one, nothing changed
// - skip when selected bit is zero, nothing changed
// - skip when byte is zero; copy form loads work register first
// - nibble swap to memory or work register, flags kept
`timescale 1ns/1ps
`include "rsse_defs.vh"

module rsse_top #(
    parameter DEPTH = 32,
    parameter PCW = 11
) (
    // clock and reset
    input wire CLK,
    input wire RSTN,
    // axi4-lite write address
    input wire S_AXI_AWVALID,
    output wire S_AXI_AWREADY,
    input wire [31:0] S_AXI_AWADDR,
    // axi4-lite write data
    input wire S_AXI_WVALID,
    output wire S_AXI_WREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    // axi4-lite write response
    output wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    output wire [1:0] S_AXI_BRESP,
    // axi4-lite read address
    input wire S_AXI_ARVALID,
    output wire S_AXI_ARREADY,
    input wire [31:0] S_AXI_ARADDR,
    // axi4-lite read data
    output wire S_AXI_RVALID,
    input wire S_AXI_RREADY,
    output wire [31:0] S_AXI_RDATA,
    output wire [1:0] S_AXI_RRESP
);

// ----------------------------------------
// state
// ----------------------------------------
reg awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
reg aw_got_ff, w_got_ff;
reg [31:0] awaddr_ff, wdata_ff, rdata_ff;
reg [3:0] wstrb_ff;
reg [1:0] bresp_ff, rresp_ff;
reg [31:0] cmd_ff;
reg [7:0] work_register_ff;
reg carry_ff, half_borrow_flag_ff, zero_ff, signed_wrap_flag_ff, master_interrupt_enable_ff;
reg skip_ff;
reg [PCW-1:0] pc_ff, stack_ff;
reg [1:0] state_ff;
reg [7:0] mem_ff [0:DEPTH-1];
integer i;

assign S_AXI_AWREADY = awready_ff;
assign S_AXI_WREADY = wready_ff;
assign S_AXI_BVALID = bvalid_ff;
assign S_AXI_BRESP = bresp_ff;
assign S_AXI_ARREADY = arready_ff;
assign S_AXI_RVALID = rvalid_ff;
assign S_AXI_RDATA = rdata_ff;
assign S_AXI_RRESP = rresp_ff;

// ----------------------------------------
// command fields and operand fetch
// ----------------------------------------
wire [4:0] op = cmd_ff[`RSSE_CMD_OP_MSB:`RSSE_CMD_OP_LSB];
wire [4:0] m_idx = cmd_ff[`RSSE_CMD_ADDR_MSB:`RSSE_CMD_ADDR_LSB];
wire [2:0] bsel = cmd_ff[`RSSE_CMD_BIT_MSB:`RSSE_CMD_BIT_LSB];
wire [7:0] imm = cmd_ff[`RSSE_CMD_IMM_MSB:`RSSE_CMD_IMM_LSB];
wire m_ok = ({27'h0000000, m_idx} < DEPTH);
wire [7:0] opnd = m_ok ? mem_ff[m_idx] : `RSSE_BYTE_ZERO;
wire busy = (state_ff != `RSSE_ST_IDLE);

// ----------------------------------------
// bus write decode
// ----------------------------------------
wire do_wr = aw_got_ff && w_got_ff && !bvalid_ff;
wire [7:0] wa = awaddr_ff[7:0];
wire wa_hi_ok = (awaddr_ff[31:8] == 24'h000000);
wire wa_mem = wa_hi_ok && (wa[`RSSE_MEM_FLAG_BIT] == `RSSE_MEM_REGION)
    && ({25'h0000000, wa[`RSSE_MEM_IDX_MSB:`RSSE_MEM_IDX_LSB]} < DEPTH);
wire wa_reg = wa_hi_ok && ((wa == `RSSE_OFF_CMD) || (wa == `RSSE_OFF_WORK) || (wa == `RSSE_OFF_STATUS)
    || (wa == `RSSE_OFF_PC) || (wa == `RSSE_OFF_STACK));
wire [31:0] wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
// command launches only when idle; a register write while busy is ignored, a memory write still lands
wire reg_wr = do_wr && !busy && wa_hi_ok;
wire launch = reg_wr && (wa == `RSSE_OFF_CMD);

// ----------------------------------------
// execute datapath
// ----------------------------------------
reg [8:0] diff9;
reg [4:0] diff5;
reg [7:0] sub_b;
reg sub_bin;
reg [7:0] res;
reg to_mem, to_work, set_sub_flags, new_carry_en, new_carry, take_skip, is_skip, is_ret, set_mie;

always @* begin
    res = opnd;
    to_mem = 1'b0;
    to_work = 1'b0;
    set_sub_flags = 1'b0;
    new_carry_en = 1'b0;
    new_carry = carry_ff;
    take_skip = 1'b0;
    is_skip = 1'b0;
    is_ret = 1'b0;
    set_mie = 1'b0;
    // shared subtractor, carry acts as inverted borrow
    sub_b = (op == `RSSE_OP_SUB_IMM) ? imm : opnd;
    sub_bin = ((op == `RSSE_OP_SUBB) || (op == `RSSE_OP_SUBB_M)) ? !carry_ff : 1'b0;
    diff9 = {1'b0, work_register_ff} - {1'b0, sub_b} - {8'h00, sub_bin};
    diff5 = {1'b0, work_register_ff[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, sub_bin};
    case (op)
        `RSSE_OP_EXIT_LIT: begin
            is_ret = 1'b1;
            res = imm;
            to_work = 1'b1;
        end
        `RSSE_OP_INT_RET: begin
            is_ret = 1'b1;
            set_mie = 1'b1;
        end
        `RSSE_OP_ROTL, `RSSE_OP_ROTL_W: begin
            res = {opnd[6:0], opnd[7]};
            to_mem = (op == `RSSE_OP_ROTL);
            to_work = (op == `RSSE_OP_ROTL_W);
        end
        `RSSE_OP_ROTLC, `RSSE_OP_ROTLC_W: begin
            res = {opnd[6:0], carry_ff};
            new_carry_en = 1'b1;
            new_carry = opnd[7];
            to_mem = (op == `RSSE_OP_ROTLC);
            to_work = (op == `RSSE_OP_ROTLC_W);
        end
        `RSSE_OP_ROTR, `RSSE_OP_ROTR_W: begin
            res = {opnd[0], opnd[7:1]};
            to_mem = (op == `RSSE_OP_ROTR);
            to_work = (op == `RSSE_OP_ROTR_W);
        end
        `RSSE_OP_ROTRC, `RSSE_OP_ROTRC_W: begin
            res = {carry_ff, opnd[7:1]};
            new_carry_en = 1'b1;
            new_carry = opnd[0];
            to_mem = (op == `RSSE_OP_ROTRC);
            to_work = (op == `RSSE_OP_ROTRC_W);
        end
        `RSSE_OP_SUBB, `RSSE_OP_SUBB_M, `RSSE_OP_SUB, `RSSE_OP_SUB_M, `RSSE_OP_SUB_IMM: begin
            res = diff9[7:0];
            set_sub_flags = 1'b1;
            to_mem = (op == `RSSE_OP_SUBB_M) || (op == `RSSE_OP_SUB_M);
            to_work = !to_mem;
        end
        `RSSE_OP_DECSKIP, `RSSE_OP_DECSKIP_W: begin
            res = opnd - 8'h01;
            is_skip = 1'b1;
            take_skip = (res == `RSSE_BYTE_ZERO);
            to_mem = (op == `RSSE_OP_DECSKIP);
            to_work = (op == `RSSE_OP_DECSKIP_W);
        end
        `RSSE_OP_INCSKIP, `RSSE_OP_INCSKIP_W: begin
            res = opnd + 8'h01;
            is_skip = 1'b1;
            take_skip = (res == `RSSE_BYTE_ZERO);
            to_mem = (op == `RSSE_OP_INCSKIP);
            to_work = (op == `RSSE_OP_INCSKIP_W);
        end
        `RSSE_OP_SET_BYTE: begin
            res = `RSSE_ALL_ONES;
            to_mem = 1'b1;
        end
        `RSSE_OP_SET_BIT: begin
            res = opnd | (8'h01 << bsel);
            to_mem = 1'b1;
        end
        `RSSE_OP_SKIP_BIT1: begin
            is_skip = 1'b1;
            take_skip = opnd[bsel];
        end
        `RSSE_OP_SKIP_BIT0: begin
            is_skip = 1'b1;
            take_skip = !opnd[bsel];
        end
        `RSSE_OP_NIB, `RSSE_OP_NIB_W: begin
            res = {opnd[3:0], opnd[7:4]};
            to_mem = (op == `RSSE_OP_NIB);
            to_work = (op == `RSSE_OP_NIB_W);
        end
        // byte zero test, copy form loads work
        `RSSE_OP_SKIP_BYTE0, `RSSE_OP_COPY_SKIP0: begin
            is_skip = 1'b1;
            take_skip = (opnd == `RSSE_BYTE_ZERO);
            to_work = (op == `RSSE_OP_COPY_SKIP0);
        end
        default: begin
            res = opnd;
        end
    endcase
end

// ----------------------------------------
// bus read decode
// ----------------------------------------
wire [7:0] ra = S_AXI_ARADDR[7:0];
wire ra_hi_ok = (S_AXI_ARADDR[31:8] == 24'h000000);
wire [4:0] ra_idx = ra[`RSSE_MEM_IDX_MSB:`RSSE_MEM_IDX_LSB];
wire ra_mem = ra_hi_ok && (ra[`RSSE_MEM_FLAG_BIT] == `RSSE_MEM_REGION) && ({27'h0000000, ra_idx} < DEPTH);
wire [6:0] status_word = {busy, skip_ff, master_interrupt_enable_ff, signed_wrap_flag_ff, zero_ff,
    half_borrow_flag_ff, carry_ff};
reg [31:0] rd_val;
reg rd_ok;

always @* begin
    rd_val = 32'h00000000;
    rd_ok = ra_hi_ok;
    if (ra_mem) begin
        rd_val = {24'h000000, mem_ff[ra_idx]};
    end else if (ra == `RSSE_OFF_CMD) begin
        rd_val = cmd_ff;
    end else if (ra == `RSSE_OFF_WORK) begin
        rd_val = {24'h000000, work_register_ff};
    end else if (ra == `RSSE_OFF_STATUS) begin
        rd_val = {25'h0000000, status_word};
    end else if (ra == `RSSE_OFF_PC) begin
        rd_val = {{(32-PCW){1'b0}}, pc_ff};
    end else if (ra == `RSSE_OFF_STACK) begin
        rd_val = {{(32-PCW){1'b0}}, stack_ff};
    end else begin
        rd_ok = 1'b0;
    end
end

// ----------------------------------------
// axi4-lite handshakes
// ----------------------------------------
always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        awaddr_ff <= 32'h00000000;
        wdata_ff <= 32'h00000000;
        wstrb_ff <= 4'h0;
        bvalid_ff <= 1'b0;
        bresp_ff <= `RSSE_RESP_OKAY;
        arready_ff <= 1'b1;
        rvalid_ff <= 1'b0;
        rdata_ff <= 32'h00000000;
        rresp_ff <= `RSSE_RESP_OKAY;
    end else begin
        // address and data taken in either order
        if (S_AXI_AWVALID && awready_ff) begin
            awready_ff <= 1'b0;
            aw_got_ff <= 1'b1;
            awaddr_ff <= S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && wready_ff) begin
            wready_ff <= 1'b0;
            w_got_ff <= 1'b1;
            wdata_ff <= S_AXI_WDATA;
            wstrb_ff <= S_AXI_WSTRB;
        end
        // response once both are held
        if (do_wr) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (wa_mem || wa_reg) ? `RSSE_RESP_OKAY : `RSSE_RESP_SLVERR;
        end
        if (bvalid_ff && S_AXI_BREADY) begin
            bvalid_ff <= 1'b0;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
        end
        // single outstanding read
        if (S_AXI_ARVALID && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_val;
            rresp_ff <= rd_ok ? `RSSE_RESP_OKAY : `RSSE_RESP_SLVERR;
        end
        if (rvalid_ff && S_AXI_RREADY) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end
end

// ----------------------------------------
// core state: bus writes, then execution
// ----------------------------------------
always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
        cmd_ff <= 32'h00000000;
        work_register_ff <= 8'h00;
        carry_ff <= 1'b0;
        half_borrow_flag_ff <= 1'b0;
        zero_ff <= 1'b0;
        signed_wrap_flag_ff <= 1'b0;
        master_interrupt_enable_ff <= 1'b0;
        skip_ff <= 1'b0;
        pc_ff <= {PCW{1'b0}};
        stack_ff <= {PCW{1'b0}};
        state_ff <= `RSSE_ST_IDLE;
        for (i = 0; i < DEPTH; i = i + 1) begin
            mem_ff[i] <= 8'h00;
        end
    end else begin
        // software writes, masked by byte strobes
        if (do_wr && wa_mem && wstrb_ff[0]) begin
            mem_ff[wa[`RSSE_MEM_IDX_MSB:`RSSE_MEM_IDX_LSB]] <= wdata_ff[7:0];
        end
        if (launch) begin
            cmd_ff <= (cmd_ff & ~wmask) | (wdata_ff & wmask);
            state_ff <= `RSSE_ST_EXEC;
        end
        if (reg_wr && (wa == `RSSE_OFF_WORK) && wstrb_ff[0]) begin
            work_register_ff <= wdata_ff[7:0];
        end
        if (reg_wr && (wa == `RSSE_OFF_STATUS) && wstrb_ff[0]) begin
            carry_ff <= wdata_ff[`RSSE_ST_CARRY];
            half_borrow_flag_ff <= wdata_ff[`RSSE_ST_HALF];
            zero_ff <= wdata_ff[`RSSE_ST_ZERO];
            signed_wrap_flag_ff <= wdata_ff[`RSSE_ST_WRAP];
            master_interrupt_enable_ff <= wdata_ff[`RSSE_ST_MIE];
        end
        if (reg_wr && (wa == `RSSE_OFF_PC)) begin
            pc_ff <= (pc_ff & ~wmask[PCW-1:0]) | (wdata_ff[PCW-1:0] & wmask[PCW-1:0]);
        end
        if (reg_wr && (wa == `RSSE_OFF_STACK)) begin
            stack_ff <= (stack_ff & ~wmask[PCW-1:0]) | (wdata_ff[PCW-1:0] & wmask[PCW-1:0]);
        end
        // execution sequence
        case (state_ff)
            `RSSE_ST_IDLE: begin
                state_ff <= launch ? `RSSE_ST_EXEC : `RSSE_ST_IDLE;
            end
            `RSSE_ST_EXEC: begin
                if (to_mem && m_ok) begin
                    mem_ff[m_idx] <= res;
                end
                if (to_work) begin
                    work_register_ff <= res;
                end
                if (new_carry_en) begin
                    carry_ff <= new_carry;
                end
                if (set_sub_flags) begin
                    carry_ff <= !diff9[8];
                    half_borrow_flag_ff <= !diff5[4];
                    zero_ff <= (diff9[7:0] == `RSSE_BYTE_ZERO);
                    signed_wrap_flag_ff <= (work_register_ff[7] != sub_b[7]) && (diff9[7] != work_register_ff[7]);
                end
                if (set_mie) begin
                    master_interrupt_enable_ff <= 1'b1;
                end
                skip_ff <= take_skip;
                // pc reload or advance, skip adds two
                if (is_ret) begin
                    pc_ff <= stack_ff;
                end else if (take_skip) begin
                    pc_ff <= pc_ff + {{(PCW-2){1'b0}}, 2'b10};
                end else begin
                    pc_ff <= pc_ff + {{(PCW-1){1'b0}}, 1'b1};
                end
                // skip-type operations add a dummy cycle
                state_ff <= is_skip ? `RSSE_ST_DUMMY : `RSSE_ST_IDLE;
            end
            `RSSE_ST_DUMMY: begin
                state_ff <= `RSSE_ST_IDLE;
            end
            default: begin
                state_ff <= `RSSE_ST_IDLE;
            end
        endcase
    end
end

endmodule // rsse_top

// ===== sim/rsse_chk_sva.sv
// bus handshake checker for the execution block
`timescale 1ns/1ps
`include "rsse_defs.vh"

module rsse_chk (
    // clock and reset
    input wire CLK,
    input wire RSTN,
    // write address and data
    input wire S_AXI_AWVALID,
    input wire S_AXI_AWREADY,
    input wire [31:0] S_AXI_AWADDR,
    input wire S_AXI_WVALID,
    input wire S_AXI_WREADY,
    // write response
    input wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [1:0] S_AXI_BRESP,
    // read channels
    input wire S_AXI_ARVALID,
    input wire S_AXI_ARREADY,
    input wire [31:0] S_AXI_ARADDR,
    input wire S_AXI_RVALID,
    input wire S_AXI_RREADY,
    input wire [31:0] S_AXI_RDATA,
    input wire [1:0] S_AXI_RRESP
);
    // ----------------------------------------
    // handshake helpers
    // ----------------------------------------
    // both write halves taken, read address taken
    wire wr_take = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    wire rd_take = S_AXI_ARVALID && S_AXI_ARREADY;

    default clocking chk_cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    // ----------------------------------------
    // response timing, holding and codes
    // ----------------------------------------
    wresp_delay_a: assert property (wr_take |-> ##2 S_AXI_BVALID) // bus contract
        else $error("write response not two cycles after take");
    wresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) // bus
        else $error("write response dropped or changed");
    rresp_delay_a: assert property (rd_take |=> S_AXI_RVALID) // bus contract
        else $error("read response not one cycle after take");
    rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) // bus
        else $error("read data dropped or changed");
    wr_blocked_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY) // bus contract
        else $error("write ready during pending response");
    rd_blocked_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) // bus contract
        else $error("read ready during pending response");
    wr_reopen_a: assert property ($fell(S_AXI_BVALID) |-> S_AXI_AWREADY && S_AXI_WREADY) // bus contract
        else $error("write ready not back after response");
    rd_reopen_a: assert property ($fell(S_AXI_RVALID) |-> S_AXI_ARREADY) // bus contract
        else $error("read ready not back after response");
    wr_unmapped_a: assert property (wr_take && S_AXI_AWADDR[31:8] != 24'h0 |->
        ##2 S_AXI_BRESP == `RSSE_RESP_SLVERR) // bus
        else $error("unmapped write not refused");
    rd_unmapped_a: assert property (rd_take && S_AXI_ARADDR[31:8] != 24'h0 |=> S_AXI_RRESP == `RSSE_RESP_SLVERR) // bus
        else $error("unmapped read not refused");
    rd_status_a: assert property (rd_take && S_AXI_ARADDR == 32'h8 |=> S_AXI_RRESP == `RSSE_RESP_OKAY) // bus
        else $error("status read refused");

    // main scenarios seen
    wr_err_c: cover property (S_AXI_BVALID && S_AXI_BREADY && S_AXI_BRESP == `RSSE_RESP_SLVERR);
    wr_ok_c: cover property (S_AXI_BVALID && S_AXI_BREADY && S_AXI_BRESP == `RSSE_RESP_OKAY);
    rd_ok_c: cover property (S_AXI_RVALID && S_AXI_RREADY && S_AXI_RRESP == `RSSE_RESP_OKAY);
endmodule // rsse_chk

// ===== sim/rsse_tb_top.sv
// self-checking bench for the rotate, subtract and skip execution block
`timescale 1ns/1ps
`include "rsse_defs.vh"

module mcu_rotate_subtract_skip_exec_tb_top;
    // ----------------------------------------
    // clock, bus drive and bookkeeping
    // ----------------------------------------
    reg CLK = 1'b0;
    reg RSTN = 1'b0;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    reg [3:0] wstrb = 4'hf;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    integer fails = 0, num_checks = 0, k = 31, j;
    reg [31:0] rd;
    reg [1:0] rsp;

    // free-running clock
    always #25 CLK = ~CLK;

    rsse_top rsse_top_inst (
        .CLK(CLK), .RSTN(RSTN),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp)
    );

    // verdict and end of run
    task test_done;
        begin
            if (fails == 0 && num_checks > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask

    // compare one value
    task check(input [31:0] seen, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask

    // a wait that ran out
    task timeout;
        begin
            fails = fails + 1;
            $display("mismatch at %0t: bus wait ran out", $time);
            test_done;
        end
    endtask

    // ----------------------------------------
    // bus tasks: ready sampled before the edge, released after it
    // ----------------------------------------
    task axi_wr(input [31:0] a, input [31:0] d);
        integer i;
        reg ta, tw, tb;
        begin
            @(posedge CLK);
            awvalid <= 1'b1;
            awaddr <= a;
            wvalid <= 1'b1;
            wdata <= d;
            bready <= 1'b1;
            tb = 1'b0;
            for (i = 0; i < 50 && !tb; i = i + 1) begin
                @(negedge CLK);
                ta = awvalid && awready;
                tw = wvalid && wready;
                tb = bready && bvalid;
                rsp = bresp;
                @(posedge CLK);
                if (ta) awvalid <= 1'b0;
                if (tw) wvalid <= 1'b0;
                if (tb) bready <= 1'b0;
            end
            if (!tb) timeout;
        end
    endtask

    task axi_rd(input [31:0] a);
        integer i;
        reg ta, tr;
        begin
            @(posedge CLK);
            arvalid <= 1'b1;
            araddr <= a;
            rready <= 1'b1;
            tr = 1'b0;
            for (i = 0; i < 50 && !tr; i = i + 1) begin
                @(negedge CLK);
                ta = arvalid && arready;
                tr = rready && rvalid;
                rd = rdata;
                rsp = rresp;
                @(posedge CLK);
                if (ta) arvalid <= 1'b0;
                if (tr) rready <= 1'b0;
            end
            if (!tr) timeout;
        end
    endtask

    // load operands, launch one op at memory byte k, check every result
    task t(input [4:0] op, input [2:0] bt, input [7:0] lit, m, w, st, ew, em, est);
        integer i;
        begin
            axi_wr(32'h80 + 4 * k, {24'h0, m});
            axi_wr(`RSSE_OFF_WORK, {24'h0, w});
            axi_wr(`RSSE_OFF_STATUS, {24'h0, st});
            axi_wr(`RSSE_OFF_PC, 32'h10);
            axi_wr(`RSSE_OFF_CMD, {lit, 5'h0, bt, 3'h0, k[4:0], 3'h0, op});
            rd = 32'h40;
            for (i = 0; i < 20 && rd[6]; i = i + 1) axi_rd(`RSSE_OFF_STATUS);
            if (rd[6]) timeout;
            check(rd & 32'h3f, {24'h0, est});
            axi_rd(`RSSE_OFF_WORK);
            check(rd, {24'h0, ew});
            axi_rd(32'h80 + 4 * k);
            check(rd, {24'h0, em}); // memory kept for work forms
            axi_rd(`RSSE_OFF_PC);
            check(rd, (op < 5'h02) ? 32'h123 : 32'h11 + est[5]); // skip advances two
            k = k - 1;
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge CLK);
        RSTN <= 1'b1;
        for (j = 0; j < 5; j = j + 1) begin
            axi_rd(4 * j);
            check(rd, 32'h0);
        end
        axi_wr(32'h104, 32'h5);
        check(rsp, `RSSE_RESP_SLVERR);
        axi_rd(32'h200);
        check(rsp, `RSSE_RESP_SLVERR);
        axi_rd(`RSSE_OFF_WORK);
        check(rd, 32'h0);
        axi_wr(`RSSE_OFF_STACK, 32'h123);
        t(5'h00,3'h0,8'h5a,8'h00,8'h11,8'h0f,8'h5a,8'h00,8'h0f);
        t(5'h01,3'h0,8'h00,8'h00,8'h22,8'h01,8'h22,8'h00,8'h11);
        t(5'h02,3'h0,8'h00,8'h81,8'h00,8'h0f,8'h00,8'h03,8'h0f);
        t(5'h03,3'h0,8'h00,8'h81,8'h00,8'h00,8'h03,8'h81,8'h00);
        t(5'h04,3'h0,8'h00,8'h80,8'h00,8'h00,8'h00,8'h00,8'h01);
        t(5'h05,3'h0,8'h00,8'h01,8'h00,8'h01,8'h03,8'h01,8'h00);
        t(5'h06,3'h0,8'h00,8'h01,8'h00,8'h0f,8'h00,8'h80,8'h0f);
        t(5'h07,3'h0,8'h00,8'h03,8'h00,8'h00,8'h81,8'h03,8'h00);
        t(5'h19,3'h0,8'h00,8'h01,8'h00,8'h00,8'h00,8'h00,8'h01);
        t(5'h1a,3'h0,8'h00,8'h02,8'h00,8'h01,8'h81,8'h02,8'h00);
        t(5'h08,3'h0,8'h00,8'h01,8'h10,8'h00,8'h0e,8'h01,8'h01);
        t(5'h09,3'h0,8'h00,8'h01,8'h00,8'h01,8'h00,8'hff,8'h00);
        t(5'h11,3'h0,8'h00,8'h01,8'h80,8'h00,8'h7f,8'h01,8'h09);
        t(5'h12,3'h0,8'h00,8'h05,8'h05,8'h00,8'h05,8'h00,8'h07);
        t(5'h13,3'h0,8'h03,8'h00,8'h05,8'h00,8'h02,8'h00,8'h03);
        t(5'h0a,3'h0,8'h00,8'h01,8'h00,8'h0f,8'h00,8'h00,8'h2f);
        t(5'h0b,3'h0,8'h00,8'h05,8'h00,8'h00,8'h04,8'h05,8'h00);
        t(5'h0c,3'h0,8'h00,8'hff,8'h00,8'h00,8'h00,8'h00,8'h20);
        t(5'h0c,3'h0,8'h00,8'h7f,8'h00,8'h00,8'h00,8'h80,8'h00);
        t(5'h0d,3'h0,8'h00,8'hff,8'h11,8'h00,8'h00,8'hff,8'h20);
        t(5'h0e,3'h0,8'h00,8'h12,8'h00,8'h6f,8'h00,8'hff,8'h0f);
        t(5'h0f,3'h7,8'h00,8'h01,8'h00,8'h0f,8'h00,8'h81,8'h0f);
        t(5'h10,3'h7,8'h00,8'h80,8'h00,8'h00,8'h00,8'h80,8'h20);
        t(5'h10,3'h0,8'h00,8'hfe,8'h00,8'h00,8'h00,8'hfe,8'h00);
        t(5'h18,3'h7,8'h00,8'h80,8'h00,8'h00,8'h00,8'h80,8'h00);
        t(5'h18,3'h0,8'h00,8'hfe,8'h00,8'h00,8'h00,8'hfe,8'h20);
        t(5'h16,3'h0,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h20);
        t(5'h16,3'h0,8'h00,8'h01,8'h00,8'h00,8'h00,8'h01,8'h00);
        t(5'h17,3'h0,8'h00,8'h42,8'h00,8'h00,8'h42,8'h42,8'h00);
        t(5'h17,3'h0,8'h00,8'h00,8'h11,8'h00,8'h00,8'h00,8'h20);
        t(5'h14,3'h0,8'h00,8'ha5,8'h00,8'h00,8'h00,8'h5a,8'h00);
        t(5'h15,3'h0,8'h00,8'h3c,8'h00,8'h00,8'hc3,8'h3c,8'h00);
        test_done;
    end
endmodule // mcu_rotate_subtract_skip_exec_tb_top

// checker beside the design top
bind rsse_top rsse_chk rsse_chk_inst (
    .CLK(CLK), .RSTN(RSTN), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP)
);
